// >>> bench/pptc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pptc_host_model (
    // clock
    input  wire logic                core_clk,
    // serial port
    output var  pptc_pkg::pptc_spi_t spi_in,
    input  wire logic                spi_miso
);
    initial spi_in = 3'b100;
    // levels held 4 cycles, twice the minimum, so miso has settled at each rise
    task automatic xfer(input logic [7:0] a, input logic [23:0] d, output logic [23:0] q);
        logic [31:0] f;
        f = {a, 8'h00, d[15:0]};
        q = 24'h000000;
        spi_in.cs_n <= 1'b0;
        for (int i = 31; i >= 0; i--) begin
            spi_in.mosi <= f[i];
            repeat (4) @(posedge core_clk);
            spi_in.sclk <= 1'b1;
            if (i < 24) q = {q[22:0], spi_miso};
            repeat (4) @(posedge core_clk);
            spi_in.sclk <= 1'b0;
        end
        spi_in.cs_n <= 1'b1;
        spi_in.mosi <= ~f[0];
        repeat (4) @(posedge core_clk);
    endtask : xfer
endmodule : pptc_host_model
`default_nettype wire

// >>> bench/pptc_phase_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pptc_phase_timer_chk (
    // clock and reset
    input wire logic                  core_clk,
    input wire logic                  srst,
    // timing outputs
    input wire pptc_pkg::pptc_phase_t phase_out,
    input wire logic [15:0]           period_counter,
    input wire logic                  period_start
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // cycles since the count last moved; catches a tick that comes too late
    logic [15:0] gap;
    always_ff @(posedge core_clk) begin
        gap <= (srst || period_counter == 16'h0000 || $changed(period_counter)) ? 16'h0001
            : gap + 16'h0001;
    end
    reset_clear_a: assert property ($fell(srst) |-> phase_out == 6'h00 &&
        period_counter == 16'h0000 && !period_start) else $error("outputs not clear");
    start_zero_a: assert property (period_start |-> period_counter == 16'h0000)
        else $error("period start off zero");
    start_pulse_a: assert property (period_start |=> !period_start)
        else $error("period start too long");
    count_step_a: assert property ($changed(period_counter) && period_counter != 16'h0000
        |-> period_counter == $past(period_counter) + 16'h0001) else $error("count skipped");
    count_hold_a: assert property ($changed(period_counter) |=>
        ($stable(period_counter) || period_counter == 16'h0000)[*8]) else $error("tick early");
    gap_max_a: assert property (period_counter != 16'h0000 |-> gap <= 16'h000A)
        else $error("tick late");
    phase_lag_a: assert property ($changed(phase_out) |-> phase_out == 6'h00 ||
        $past(period_counter, 1) != $past(period_counter, 2)) else $error("phase lag");
    phase_hold_a: assert property ($changed(phase_out) |=>
        ($stable(phase_out) || phase_out == 6'h00)[*8]) else $error("phase glitch");
endmodule : pptc_phase_timer_chk
bind pptc_phase_timer pptc_phase_timer_chk chk_u (.core_clk(core_clk), .srst(srst),
    .phase_out(phase_out), .period_counter(period_counter), .period_start(period_start));
`default_nettype wire

// >>> bench/test_pulse_phase_timing_compare.sv
`timescale 1ns/1ps
`default_nettype none
module test_pulse_phase_timing_compare;
    localparam logic [15:0] PERIOD = 16'h0063;
    logic                  core_clk = 1'b0;
    logic                  srst = 1'b1;
    pptc_pkg::pptc_spi_t   spi_in;
    logic                  spi_miso;
    pptc_pkg::pptc_phase_t phase_out;
    logic [15:0]           period_counter;
    logic                  period_start;
    logic [15:0]           st [6];
    logic [15:0]           en [6];
    logic [23:0]           q;
    int                    errors = 0;
    int                    checks = 0;
    int                    cyc = 0;
    always #12.5 core_clk = ~core_clk;
    pptc_host_model host_u (.core_clk(core_clk), .spi_in(spi_in), .spi_miso(spi_miso));
    pptc_phase_timer dut_u (.core_clk(core_clk), .srst(srst), .spi_in(spi_in),
        .spi_miso(spi_miso), .phase_out(phase_out), .period_counter(period_counter),
        .period_start(period_start));
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic rd_cmp(input logic [7:0] a, input logic [23:0] x);
        logic [23:0] r;
        host_u.xfer(a, 24'h000000, r);
        cmp(r, x);
    endtask : rd_cmp
    task automatic t_regs();
        host_u.xfer(8'h00, 24'h000001, q);
        for (int a = 3; a <= 11; a++) rd_cmp(8'(a), 24'h000000);
        rd_cmp(8'h20, 24'h000000);
        host_u.xfer(8'h00, 24'h000000, q);
        for (int i = 0; i < 6; i++) begin
            st[i] = 16'(5 + 16 * i);
            en[i] = st[i] + 16'h0009;
            host_u.xfer(8'(2 * i + 1), {8'hFF, st[i]}, q);
            host_u.xfer(8'(2 * i + 2), {8'hFF, en[i]}, q);
        end
        host_u.xfer(pptc_pkg::ADDR_REPETITION_PERIOD, {8'h00, PERIOD}, q);
        host_u.xfer(8'h00, 24'h000001, q);
        for (int a = 1; a <= 12; a++) rd_cmp(8'(a), {8'h00, a[0] ? st[a/2] : en[a/2-1]});
        host_u.xfer(8'h00, 24'h000000, q);
    endtask : t_regs
    task automatic t_timing();
        logic [5:0]  e;
        logic [15:0] c;
        int          n;
        n = 0;
        while (period_start !== 1'b1 && n < 3000) begin @(negedge core_clk); n++; end
        n = 0;
        do begin @(negedge core_clk); n++; end while (period_start !== 1'b1 && n < 3000);
        cmp(24'(n), 24'((PERIOD + 1) * 10));
        for (int k = 0; k <= PERIOD; k++) begin
            c = period_counter;
            n = 0;
            while (period_counter === c && n < 20) begin @(negedge core_clk); n++; end
            repeat (4) @(negedge core_clk);
            for (int i = 0; i < 6; i++) e[i] = period_counter >= st[i] && period_counter < en[i];
            cmp(24'(phase_out), 24'(e));
        end
        @(posedge core_clk);
    endtask : t_timing
    task automatic t_sw_rst();
        host_u.xfer(8'h00, 24'h000008, q);
        repeat (2) @(negedge core_clk);
        cmp({8'h00, period_counter}, 24'h000000);
        @(posedge core_clk);
        host_u.xfer(8'h00, 24'h000001, q);
        rd_cmp(8'h01, 24'h000000);
        rd_cmp(8'h0C, 24'h000000);
        rd_cmp(pptc_pkg::ADDR_REPETITION_PERIOD, 24'h000000);
        cmp({18'h00000, phase_out}, 24'h000000);
        host_u.xfer(8'h00, 24'h000000, q);
    endtask : t_sw_rst
    task automatic t_timer_rst();
        host_u.xfer(8'h00, 24'h000002, q);
        repeat (30) @(posedge core_clk);
        cmp({period_counter, 2'b00, phase_out}, 24'h000000);
        host_u.xfer(8'h00, 24'h000000, q);
        repeat (30) @(posedge core_clk);
        cmp(24'(period_counter != 16'h0000), 24'h000001);
    endtask : t_timer_rst
    task automatic final_report();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    initial begin
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_timing();
        t_timer_rst();
        t_sw_rst();
        final_report();
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            errors++;
            final_report();
        end
    end
endmodule : test_pulse_phase_timing_compare
`default_nettype wire

// >>> core/pptc_phase_timer.sv
// Notes on behaviour
// - emitter-B sample ends at its 16-bit count
// - counts are 4 MHz ticks from period start
// - emitter B on at count in 03h
// - emitter B off at count in 04h
// - ambient-B sample starts at count in 05h
// - ambient-B sample ends at count in 06h
// - emitter-A sample starts at count in 07h
// - emitter-A sample ends at count in 08h
// - emitter A on at count in 09h
// - emitter A off at count in 0Ah
// - ambient-A sample starts at count in 0Bh
// - all count registers reset to zero
// - counter repeats after the programmed last count
// - timer reset bit holds counters cleared
`timescale 1ns/1ps
`default_nettype none

module pptc_phase_timer #(
    parameter int TICK_DIV = pptc_pkg::TICK_DIV,
    parameter int CNT_W    = pptc_pkg::CNT_W
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  srst,
    // serial register port
    input  wire pptc_pkg::pptc_spi_t   spi_in,
    output var  logic                  spi_miso,
    // timing outputs
    output var  pptc_pkg::pptc_phase_t phase_out,
    output var  logic [CNT_W-1:0]      period_counter,
    output var  logic                  period_start
);

    localparam int WORD_W  = pptc_pkg::WORD_W;
    localparam int FRAME_W = pptc_pkg::FRAME_W;
    localparam int ADDR_W  = pptc_pkg::ADDR_W;
    localparam int N_PHASE = pptc_pkg::N_PHASE;
    localparam int DIV_W   = $clog2(TICK_DIV);

    // 4 MHz tick enable
    logic [DIV_W-1:0] div_cnt;
    logic             tick;
    logic             tick_d;
    wire              div_last = (div_cnt == DIV_W'(TICK_DIV - 1));

    // serial port state
    logic               sclk_q;
    logic [5:0]         bit_cnt;
    logic [FRAME_W-2:0] shift_in;
    logic [WORD_W-1:0]  shift_out;

    // register file
    logic [WORD_W-1:0] word_mem [1:12];
    logic [WORD_W-1:0] period_reg;
    logic              read_en;
    logic              timer_rst;
    logic              sw_rst;
    logic [N_PHASE-1:0] phase_q;

    wire reg_clear = srst | sw_rst;

    // serial decode
    wire sclk_rise = spi_in.sclk & ~sclk_q & ~spi_in.cs_n;
    wire sclk_fall = ~spi_in.sclk & sclk_q & ~spi_in.cs_n;
    wire [FRAME_W-1:0] frame = {shift_in, spi_in.mosi};
    wire frame_done = sclk_rise & (bit_cnt == 6'(FRAME_W - 1));
    wire addr_done  = sclk_rise & (bit_cnt == 6'(ADDR_W - 1));
    wire [ADDR_W-1:0] wr_addr = frame[FRAME_W-1 -: ADDR_W];
    wire [WORD_W-1:0] wr_data = frame[WORD_W-1:0];
    wire [ADDR_W-1:0] rd_addr = frame[ADDR_W-1:0];
    wire data_phase = (bit_cnt >= 6'(ADDR_W)) & (bit_cnt < 6'(FRAME_W));

    // while read mode is on only the control register accepts writes
    wire wr_ctrl   = frame_done & (wr_addr == pptc_pkg::ADDR_CONTROL);
    wire wr_phase  = frame_done & ~read_en
                   & (wr_addr >= pptc_pkg::ADDR_FIRST_PHASE)
                   & (wr_addr <= pptc_pkg::ADDR_LAST_PHASE);
    wire wr_period = frame_done & ~read_en & (wr_addr == pptc_pkg::ADDR_REPETITION_PERIOD);

    wire rd_is_phase = (rd_addr >= pptc_pkg::ADDR_FIRST_PHASE)
                     & (rd_addr <= pptc_pkg::ADDR_LAST_PHASE);
    wire [WORD_W-1:0] rd_word =
        rd_is_phase ? word_mem[rd_addr[3:0]] :
        (rd_addr == pptc_pkg::ADDR_REPETITION_PERIOD) ? period_reg :
        pptc_pkg::RESET_WORD;

    // counter wraps after the programmed last count
    wire cnt_wrap = (period_counter == period_reg[CNT_W-1:0]);
    wire [CNT_W-1:0] next_counter = cnt_wrap ? CNT_W'(0) : period_counter + CNT_W'(1);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            div_cnt <= '0;
            tick    <= 1'b0;
            tick_d  <= 1'b0;
        end else begin
            div_cnt <= div_last ? '0 : div_cnt + DIV_W'(1);
            tick    <= div_last;
            tick_d  <= tick;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sclk_q    <= 1'b0;
            bit_cnt   <= '0;
            shift_in  <= '0;
            shift_out <= '0;
            spi_miso  <= 1'b0;
        end else begin
            sclk_q <= spi_in.sclk;
            if (spi_in.cs_n) begin
                bit_cnt  <= '0;
                spi_miso <= 1'b0;
            end else if (sclk_rise) begin
                shift_in <= frame[FRAME_W-2:0];
                bit_cnt  <= frame_done ? '0 : bit_cnt + 6'd1;
                if (addr_done) begin
                    shift_out <= read_en ? rd_word : pptc_pkg::RESET_WORD;
                end
            end else if (sclk_fall && data_phase) begin
                spi_miso  <= shift_out[WORD_W-1];
                shift_out <= {shift_out[WORD_W-2:0], 1'b0};
            end
        end
    end

    // control register; software reset is a one-cycle pulse
    always_ff @(posedge core_clk) begin
        if (reg_clear) begin
            read_en   <= 1'b0;
            timer_rst <= 1'b0;
            sw_rst    <= 1'b0;
        end else begin
            sw_rst <= wr_ctrl & wr_data[pptc_pkg::CTRL_SW_RST_BIT];
            if (wr_ctrl) begin
                read_en   <= wr_data[pptc_pkg::CTRL_READ_EN_BIT];
                timer_rst <= wr_data[pptc_pkg::CTRL_TIMER_RST_BIT];
            end
        end
    end

    // stored as written; upper bits are the host's to keep zero
    always_ff @(posedge core_clk) begin
        if (reg_clear) begin
            for (int i = 1; i <= 12; i++) begin
                word_mem[i] <= pptc_pkg::RESET_WORD;
            end
            period_reg <= pptc_pkg::RESET_WORD;
        end else begin
            if (wr_phase) begin
                word_mem[wr_addr[3:0]] <= wr_data;
            end
            if (wr_period) begin
                period_reg <= wr_data;
            end
        end
    end

    // period counter
    always_ff @(posedge core_clk) begin
        if (reg_clear || timer_rst) begin
            period_counter <= pptc_pkg::RESET_CNT;
            period_start   <= 1'b0;
        end else begin
            period_start <= tick & cnt_wrap;
            if (tick) begin
                period_counter <= next_counter;
            end
        end
    end

    // only the low 16 bits compare, so stray upper bits from the host
    // cannot push a match out of range
    wire [CNT_W-1:0] emitter_b_sample_start = word_mem[1][CNT_W-1:0];
    wire [CNT_W-1:0] emitter_b_sample_end   = word_mem[2][CNT_W-1:0];
    wire [CNT_W-1:0] emitter_b_on_start     = word_mem[3][CNT_W-1:0];
    wire [CNT_W-1:0] emitter_b_on_end       = word_mem[4][CNT_W-1:0];
    wire [CNT_W-1:0] ambient_b_sample_start = word_mem[5][CNT_W-1:0];
    wire [CNT_W-1:0] ambient_b_sample_end   = word_mem[6][CNT_W-1:0];
    // bit 16 of the emitter-A sample pair is ignored as well
    wire [CNT_W-1:0] emitter_a_sample_start = word_mem[7][CNT_W-1:0];
    wire [CNT_W-1:0] emitter_a_sample_end   = word_mem[8][CNT_W-1:0];
    wire [CNT_W-1:0] emitter_a_on_start     = word_mem[9][CNT_W-1:0];
    wire [CNT_W-1:0] emitter_a_on_end       = word_mem[10][CNT_W-1:0];
    wire [CNT_W-1:0] ambient_a_sample_start = word_mem[11][CNT_W-1:0];
    wire [CNT_W-1:0] ambient_a_sample_end   = word_mem[12][CNT_W-1:0];

    // windows compare one cycle after the tick, once the counter has moved
    wire phase_clear = reg_clear | timer_rst;

    // one window per phase
    wire win_emitter_b_sample;
    wire win_emitter_b_on;
    wire win_ambient_b_sample;
    wire win_emitter_a_sample;
    wire win_emitter_a_on;
    wire win_ambient_a_sample;

    pptc_phase_window #(.CNT_W(CNT_W)) win_emitter_b_sample_u (
        .core_clk  (core_clk),
        .clear     (phase_clear),
        .step      (tick_d),
        .count     (period_counter),
        .start_cnt (emitter_b_sample_start),
        .end_cnt   (emitter_b_sample_end),
        .window    (win_emitter_b_sample)
    );

    pptc_phase_window #(.CNT_W(CNT_W)) win_emitter_b_on_u (
        .core_clk  (core_clk),
        .clear     (phase_clear),
        .step      (tick_d),
        .count     (period_counter),
        .start_cnt (emitter_b_on_start),
        .end_cnt   (emitter_b_on_end),
        .window    (win_emitter_b_on)
    );

    pptc_phase_window #(.CNT_W(CNT_W)) win_ambient_b_sample_u (
        .core_clk  (core_clk),
        .clear     (phase_clear),
        .step      (tick_d),
        .count     (period_counter),
        .start_cnt (ambient_b_sample_start),
        .end_cnt   (ambient_b_sample_end),
        .window    (win_ambient_b_sample)
    );

    pptc_phase_window #(.CNT_W(CNT_W)) win_emitter_a_sample_u (
        .core_clk  (core_clk),
        .clear     (phase_clear),
        .step      (tick_d),
        .count     (period_counter),
        .start_cnt (emitter_a_sample_start),
        .end_cnt   (emitter_a_sample_end),
        .window    (win_emitter_a_sample)
    );

    pptc_phase_window #(.CNT_W(CNT_W)) win_emitter_a_on_u (
        .core_clk  (core_clk),
        .clear     (phase_clear),
        .step      (tick_d),
        .count     (period_counter),
        .start_cnt (emitter_a_on_start),
        .end_cnt   (emitter_a_on_end),
        .window    (win_emitter_a_on)
    );

    pptc_phase_window #(.CNT_W(CNT_W)) win_ambient_a_sample_u (
        .core_clk  (core_clk),
        .clear     (phase_clear),
        .step      (tick_d),
        .count     (period_counter),
        .start_cnt (ambient_a_sample_start),
        .end_cnt   (ambient_a_sample_end),
        .window    (win_ambient_a_sample)
    );

    // bit order follows the phase struct, last member lowest
    assign phase_q = {
        win_ambient_a_sample,
        win_emitter_a_on,
        win_emitter_a_sample,
        win_ambient_b_sample,
        win_emitter_b_on,
        win_emitter_b_sample
    };

    assign phase_out = pptc_pkg::pptc_phase_t'(phase_q);

endmodule : pptc_phase_timer

// one phase window: opens on its start match, closes on its end match
module pptc_phase_window #(
    parameter int CNT_W = pptc_pkg::CNT_W
) (
    // clock and clear
    input  wire logic             core_clk,
    input  wire logic             clear,
    // timer
    input  wire logic             step,
    input  wire logic [CNT_W-1:0] count,
    // programmed edges
    input  wire logic [CNT_W-1:0] start_cnt,
    input  wire logic [CNT_W-1:0] end_cnt,
    // window level
    output var  logic             window
);

    wire hit_start = step & (count == start_cnt);
    wire hit_end   = step & (count == end_cnt);

    // end wins when both match, giving an empty window
    always_ff @(posedge core_clk) begin
        if (clear) begin
            window <= 1'b0;
        end else if (hit_end) begin
            window <= 1'b0;
        end else if (hit_start) begin
            window <= 1'b1;
        end
    end

endmodule : pptc_phase_window

`default_nettype wire

// >>> include/pptc_pkg.sv
`default_nettype none
package pptc_pkg;

    // core clock and the pulse timing clock it is divided down to
    localparam int CORE_CLK_HZ  = 40_000_000;
    localparam int TIMER_CLK_HZ = 4_000_000;
    localparam int TICK_DIV     = CORE_CLK_HZ / TIMER_CLK_HZ;

    // widths
    localparam int WORD_W  = 24;
    localparam int CNT_W   = 16;
    localparam int ADDR_W  = 8;
    localparam int FRAME_W = ADDR_W + WORD_W;
    localparam int N_PHASE = 6;

    // register offsets
    localparam logic [7:0] ADDR_CONTROL                = 8'h00;
    localparam logic [7:0] ADDR_EMITTER_B_SAMPLE_START = 8'h01;
    localparam logic [7:0] ADDR_EMITTER_B_SAMPLE_END   = 8'h02;
    localparam logic [7:0] ADDR_EMITTER_B_ON_START     = 8'h03;
    localparam logic [7:0] ADDR_EMITTER_B_ON_END       = 8'h04;
    localparam logic [7:0] ADDR_AMBIENT_B_SAMPLE_START = 8'h05;
    localparam logic [7:0] ADDR_AMBIENT_B_SAMPLE_END   = 8'h06;
    localparam logic [7:0] ADDR_EMITTER_A_SAMPLE_START = 8'h07;
    localparam logic [7:0] ADDR_EMITTER_A_SAMPLE_END   = 8'h08;
    localparam logic [7:0] ADDR_EMITTER_A_ON_START     = 8'h09;
    localparam logic [7:0] ADDR_EMITTER_A_ON_END       = 8'h0A;
    localparam logic [7:0] ADDR_AMBIENT_A_SAMPLE_START = 8'h0B;
    localparam logic [7:0] ADDR_AMBIENT_A_SAMPLE_END   = 8'h0C;
    localparam logic [7:0] ADDR_REPETITION_PERIOD      = 8'h1D;
    localparam logic [7:0] ADDR_FIRST_PHASE            = ADDR_EMITTER_B_SAMPLE_START;
    localparam logic [7:0] ADDR_LAST_PHASE             = ADDR_AMBIENT_A_SAMPLE_END;

    // control register fields
    localparam int CTRL_READ_EN_BIT   = 0;
    localparam int CTRL_TIMER_RST_BIT = 1;
    localparam int CTRL_SW_RST_BIT    = 3;

    // reset values
    localparam logic [23:0] RESET_WORD = 24'h000000;
    localparam logic [15:0] RESET_CNT  = 16'h0000;

    // serial port pins, all sampled on core_clk
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } pptc_spi_t;

    // phase windows; bit i is phase i, registers 2i+1 (start) and 2i+2 (end)
    typedef struct packed {
        logic ambient_a_sample;
        logic emitter_a_on;
        logic emitter_a_sample;
        logic ambient_b_sample;
        logic emitter_b_on;
        logic emitter_b_sample;
    } pptc_phase_t;

endpackage : pptc_pkg
`default_nettype wire
